// [dioia_pkg.sv]
package dioia_pkg;
  // Register byte offsets
  localparam logic [5:0] OFS_CLOSE = 6'h00;
  localparam logic [5:0] OFS_OPEN  = 6'h04;
  localparam logic [5:0] OFS_WORD  = 6'h08;
  localparam logic [5:0] OFS_LOAD  = 6'h0C;
  localparam logic [5:0] OFS_CONT  = 6'h10;
  localparam logic [5:0] OFS_MASK  = 6'h14;
  localparam logic [5:0] OFS_FLAG  = 6'h18;
  localparam logic [5:0] OFS_SENSE = 6'h1C;
  localparam logic [5:0] OFS_CTRL  = 6'h20;
  localparam logic [5:0] OFS_IST   = 6'h24;
  localparam logic [5:0] OFS_ICLR  = 6'h28;
  localparam logic [5:0] OFS_IEN   = 6'h2C;
  // Control bits
  localparam int CTRL_SRC_OUT = 0;
  localparam int CTRL_NARROW  = 1;
  localparam int CTRL_ONE     = 2;
  localparam int CTRL_REINIT  = 3;
  localparam int CONT_RUN     = 0;
  // Interrupt status bits
  localparam int IST_FLAG = 0;
  localparam int IST_RDG  = 1;
  localparam int IST_BAD  = 2;
  // Reset values
  localparam logic [15:0] OUT_RST   = 16'h0000;
  localparam logic [7:0]  MASK_RST  = 8'h00;
  localparam logic [7:0]  SENSE_RST = 8'hFF;
  localparam logic [2:0]  CTRL_RST  = 3'h0;
  localparam logic [2:0]  IEN_RST   = 3'h0;
  // Continuous read resample period
  localparam int CLK_HZ    = 40_000_000;
  localparam int SAMPLE_US = 100;
  localparam int SAMPLE_CYC = SAMPLE_US * (CLK_HZ / 1_000_000);
  localparam logic [11:0] SAMPLE_LAST = 12'(SAMPLE_CYC - 1);

  typedef enum logic {RD_IDLE, RD_RUN} dioia_rd_e;

  // Word returned by load and continuous reads
  function automatic logic [15:0] dioia_word(
    input logic src_out, input logic narrow,
    input logic [15:0] din, input logic [15:0] dout);
    logic [15:0] w;
    w = src_out ? dout : din;
    if (src_out && narrow) w[15:8] = 8'h00;
    return w;
  endfunction

  // Byte-lane merge for stored fields
  function automatic logic [15:0] dioia_merge(
    input logic [15:0] old, input logic [15:0] nw,
    input logic [15:0] bem);
    return (old & ~bem) | (nw & bem);
  endfunction
endpackage

// [dioia_irq_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface dioia_irq_if;
  logic [7:0] level;
  logic [7:0] sense;
  logic [7:0] mask;
  logic [7:0] clr;
  logic       reinit;
  logic [7:0] flags;
  logic       set_evt;
  logic       req;
  modport ctl  (output level, sense, mask, clr, reinit,
                input flags, set_evt, req);
  modport unit (input level, sense, mask, clr, reinit,
                output flags, set_evt, req);
endinterface
`default_nettype wire

// [dioia_irq_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module dioia_irq_unit (
  input  wire logic   clk_i, // System clock
  input  wire logic   rst_i, // Async reset
  dioia_irq_if.unit   irq    // Flag unit side
);
  logic [7:0] prev_q;
  logic [7:0] flags_q;

  // Edge pick per sense bit
  wire logic [7:0] rise = irq.level & ~prev_q;
  wire logic [7:0] fall = ~irq.level & prev_q;
  wire logic [7:0] hit  = (irq.sense & rise)
                        | (~irq.sense & fall);
  // Set wins over clear so no edge is lost
  wire logic [7:0] kept = irq.reinit ? 8'h00
                        : (flags_q & ~irq.clr);
  wire logic [7:0] flags_d = kept | hit;

  assign irq.flags   = flags_q;
  assign irq.set_evt = |hit;
  assign irq.req     = |(flags_q & irq.mask);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_q  <= 8'h00;
      flags_q <= 8'h00;
    end else begin
      prev_q  <= irq.level;
      flags_q <= flags_d;
    end
  end

  edge_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|hit) |=> ((flags_q & $past(hit)) == $past(hit)))
    else $error("Edge did not set flag");
  rise_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (irq.sense[0] && rise[0]) |=> flags_q[0])
    else $error("Rising edge missed");
  fall_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!irq.sense[1] && fall[1]) |=> flags_q[1])
    else $error("Falling edge missed");
  flag_holds_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (flags_q[2] && !irq.clr[2] && !irq.reinit) |=> flags_q[2])
    else $error("Flag dropped without clear");
endmodule // dioia_irq_unit
`default_nettype wire

// [dioia_top.sv]
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dioia_top
  import dioia_pkg::*;
(
  input  wire logic        clk_i,             // 40 MHz clock
  input  wire logic        rst_i,             // Async reset
  input  wire logic [5:0]  avs_address_i,     // Byte address
  input  wire logic        avs_read_i,        // Read request
  input  wire logic        avs_write_i,       // Write request
  input  wire logic [31:0] avs_writedata_i,   // Write data
  input  wire logic [3:0]  avs_byteenable_i,  // Byte lanes
  output logic      [31:0] avs_readdata_o,    // Read data
  output logic             avs_waitrequest_o, // Stall
  input  wire logic [15:0] din_i,             // Input channels
  output logic      [15:0] dout_o,            // 1 = closed
  output logic      [15:0] rdg_data_o,        // Reading word
  output logic             rdg_stb_o,         // Reading pulse
  output logic             dig_irq_o,         // To mainframe
  output logic             irq_o              // Bus interrupt
);

  // Registers
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [15:0] out_q;
  logic [7:0]  mask_q;
  logic [7:0]  sense_q;
  logic [2:0]  ctrl_q;
  logic [2:0]  ist_q;
  logic [2:0]  ien_q;
  dioia_rd_e   rd_q;
  logic [11:0] cnt_q;
  logic [15:0] rdg_q;
  logic        stb_q;

  dioia_irq_if irq_bus ();

  // One wait state: the first cycle loads read data
  wire logic access = avs_read_i | avs_write_i;
  wire logic wr_fire = avs_write_i & ack_q;
  wire logic rd_fire = avs_read_i & ack_q;
  wire logic rd_load = avs_read_i & ~ack_q;
  assign avs_waitrequest_o = access & ~ack_q;

  // Address decode
  wire logic a_close = avs_address_i == OFS_CLOSE;
  wire logic a_open  = avs_address_i == OFS_OPEN;
  wire logic a_word  = avs_address_i == OFS_WORD;
  wire logic a_load  = avs_address_i == OFS_LOAD;
  wire logic a_cont  = avs_address_i == OFS_CONT;
  wire logic a_mask  = avs_address_i == OFS_MASK;
  wire logic a_flag  = avs_address_i == OFS_FLAG;
  wire logic a_sense = avs_address_i == OFS_SENSE;
  wire logic a_ctrl  = avs_address_i == OFS_CTRL;
  wire logic a_ist   = avs_address_i == OFS_IST;
  wire logic a_iclr  = avs_address_i == OFS_ICLR;
  wire logic a_ien   = avs_address_i == OFS_IEN;
  wire logic mapped  = a_close | a_open | a_word
                     | a_load | a_cont | a_mask
                     | a_flag | a_sense | a_ctrl
                     | a_ist | a_iclr | a_ien;

  // Lane mask; unwritten lanes act as zero bits
  wire logic [15:0] bem = {{8{avs_byteenable_i[1]}},
                           {8{avs_byteenable_i[0]}}};
  wire logic [15:0] wd = avs_writedata_i[15:0] & bem;

  // Reinit is an action bit, it is not stored
  wire logic reinit = wr_fire & a_ctrl
                    & wd[CTRL_REINIT];

  // Channel command decode
  wire logic do_close = wr_fire & a_close;
  wire logic do_open  = wr_fire & a_open;
  wire logic do_word  = wr_fire & a_word;

  // Output channel next state
  wire logic [15:0] out_d =
      reinit   ? OUT_RST :
      do_close ? (out_q | wd) :
      do_open  ? (out_q & ~wd) :
      do_word  ? dioia_merge(out_q,
                   avs_writedata_i[15:0], bem) :
      out_q;

  // Word seen by load and continuous reads
  wire logic [15:0] word_now =
      dioia_word(ctrl_q[CTRL_SRC_OUT],
                 ctrl_q[CTRL_NARROW], din_i, out_q);

  // Continuous reader control
  wire logic cont_wr = wr_fire & a_cont;
  wire logic start = cont_wr & wd[CONT_RUN];
  wire logic stop  = (cont_wr & ~wd[CONT_RUN]) | reinit;
  wire logic tick  = (rd_q == RD_RUN)
                   & (cnt_q == SAMPLE_LAST);
  wire logic emit  = start | tick;
  wire logic one   = ctrl_q[CTRL_ONE];

  // Reader state; single mode stops after one word
  dioia_rd_e rd_d;
  always_comb begin
    rd_d = rd_q;
    unique case (rd_q)
      RD_IDLE: begin
        if (start && !one) rd_d = RD_RUN;
      end
      RD_RUN: begin
        if (stop || one) rd_d = RD_IDLE;
        else if (start) rd_d = RD_RUN;
      end
    endcase
  end

  // Divider restarts with each start
  wire logic [11:0] cnt_d =
      (start || rd_q != RD_RUN || tick) ? 12'h000
      : cnt_q + 12'h001;

  // Read data mux
  wire logic [15:0] rd_mux =
      a_word  ? out_q :
      a_load  ? word_now :
      a_cont  ? rdg_q :
      a_mask  ? {8'h00, mask_q} :
      a_flag  ? {8'h00, irq_bus.flags} :
      a_sense ? {8'h00, sense_q} :
      a_ctrl  ? {13'h0000, ctrl_q} :
      a_ist   ? {13'h0000, ist_q} :
      a_ien   ? {13'h0000, ien_q} :
      16'h0000;

  // Read of FLAG clears just the bits it reported
  wire logic [7:0] flag_clr =
      (rd_fire & a_flag) ? rdata_q[7:0]
      : 8'h00;

  // Status events; set wins over clear
  wire logic [2:0] ev;
  assign ev[IST_FLAG] = irq_bus.set_evt;
  assign ev[IST_RDG]  = emit;
  assign ev[IST_BAD]  = (wr_fire | rd_fire) & ~mapped;
  wire logic [2:0] iclr = (wr_fire & a_iclr)
                        ? wd[2:0] : 3'h0;
  wire logic [2:0] ist_d = (ist_q & ~iclr) | ev;

  // Flag unit hookup
  assign irq_bus.level  = din_i[7:0];
  assign irq_bus.sense  = sense_q;
  assign irq_bus.mask   = mask_q;
  assign irq_bus.clr    = flag_clr;
  assign irq_bus.reinit = reinit;

  dioia_irq_unit u_irq (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .irq   (irq_bus.unit)
  );

  // Outputs
  assign avs_readdata_o = rdata_q;
  assign dout_o     = out_q;
  assign rdg_data_o = rdg_q;
  assign rdg_stb_o  = stb_q;
  assign dig_irq_o  = irq_bus.req;
  assign irq_o      = |(ist_q & ien_q);

  // Bus handshake and read capture
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= access & ~ack_q;
      if (rd_load) rdata_q <= {16'h0000, rd_mux};
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_q   <= OUT_RST;
      mask_q  <= MASK_RST;
      sense_q <= SENSE_RST;
      ctrl_q  <= CTRL_RST;
      ien_q   <= IEN_RST;
    end else begin
      out_q <= out_d;
      if (reinit) begin
        mask_q  <= MASK_RST;
        sense_q <= SENSE_RST;
      end else begin
        if (wr_fire && a_mask) mask_q <= wd[7:0];
        if (wr_fire && a_sense) sense_q <= wd[7:0];
      end
      if (wr_fire && a_ctrl) ctrl_q <= wd[2:0];
      if (wr_fire && a_ien) ien_q <= wd[2:0];
    end
  end

  // Reader, divider and status
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_q  <= RD_IDLE;
      cnt_q <= 12'h000;
      rdg_q <= 16'h0000;
      stb_q <= 1'b0;
      ist_q <= 3'h0;
    end else begin
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      stb_q <= emit;
      if (emit) rdg_q <= word_now;
      ist_q <= ist_d;
    end
  end

  // Cycles since the last reading while running; a stuck divider lets it overrun
  logic [11:0] gap_q;
  wire logic [11:0] gap_d = (rdg_stb_o || rd_q != RD_RUN) ? 12'h000
                          : gap_q + 12'h001;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_q <= 12'h000;
    end else begin
      gap_q <= gap_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  close_keeps_a: assert property (
    do_close && !reinit |=> dout_o == ($past(out_q) | $past(wd)))
    else $error("Close result wrong");

  open_keeps_a: assert property (
    do_open && !reinit |=> dout_o == ($past(out_q) & ~$past(wd)))
    else $error("Open result wrong");

  word_write_a: assert property (
    do_word && !reinit && avs_byteenable_i[1:0] == 2'h3
    |=> dout_o == $past(avs_writedata_i[15:0]))
    else $error("Word write wrong");

  load_input_a: assert property (
    rd_load && a_load && !ctrl_q[CTRL_SRC_OUT]
    |=> !avs_waitrequest_o
        && avs_readdata_o == {16'h0000, $past(din_i)})
    else $error("Input load wrong");

  load_narrow_a: assert property (
    rd_load && a_load && ctrl_q[CTRL_SRC_OUT] && ctrl_q[CTRL_NARROW]
    |=> avs_readdata_o == {24'h000000, $past(out_q[7:0])})
    else $error("Narrow load wrong");

  cont_resend_a: assert property (
    rd_q == RD_RUN |-> gap_q <= SAMPLE_LAST)
    else $error("Continuous read stalled");

  single_once_a: assert property (
    start && one |=> rdg_stb_o ##1 (!rdg_stb_o && rd_q == RD_IDLE))
    else $error("Single mode sent extra");

  flag_read_a: assert property (
    rd_load && a_flag |=> avs_readdata_o[7:0] == $past(irq_bus.flags))
    else $error("Flag read wrong");

  mask_gates_a: assert property (
    (irq_bus.flags & mask_q) == 8'h00 |-> !dig_irq_o)
    else $error("Masked flag raised request");

  flag_clears_a: assert property (
    rd_fire && a_flag && !irq_bus.set_evt
    |=> (irq_bus.flags & $past(rdata_q[7:0])) == 8'h00)
    else $error("Flag not cleared by read");

  cont_run_c: cover property (rd_q == RD_RUN && tick);
  flag_irq_c: cover property ($rose(dig_irq_o));
  bad_addr_c: cover property (ev[IST_BAD]);
endmodule // dioia_top
`default_nettype wire

// [dioia_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Mainframe processor side: issues one register access at a time
module dioia_host (
  input  wire logic        clk_i,   // Bus clock
  output logic      [5:0]  addr_o,  // Byte address
  output logic             rd_o,    // Read request
  output logic             wr_o,    // Write request
  output logic      [31:0] wdata_o, // Write data
  input  wire logic [31:0] rdata_i, // Read data
  input  wire logic        wait_i   // Stall
);
  // Idle bus from time zero
  initial begin
    addr_o = 6'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 32'h0;
  end
  // Hold the request until waitrequest samples low at a rising edge;
  // read data is taken and the request dropped at that same edge
  task automatic access(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= w;
    rd_o <= !w;
    do begin
      @(posedge clk_i);
    end while (wait_i !== 1'b0);
    q = rdata_i;
    rd_o <= 1'b0;
    wr_o <= 1'b0;
  endtask
endmodule // dioia_host
`default_nettype wire

// [tb_digital_io_interrupt_assembly.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_digital_io_interrupt_assembly;
  import dioia_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic [5:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wd;
  logic [31:0] rdat;
  logic        wt;
  logic [15:0] din;
  logic [15:0] dout;
  logic [15:0] rdg;
  logic        stb;
  logic        dirq;
  logic        irq;
  logic [15:0] mdl;
  logic [15:0] v;
  logic [31:0] q;
  bit          got;
  int          error_cnt = 0;
  int          check_count = 0;

  dioia_top DUT (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
    .din_i(din), .dout_o(dout), .rdg_data_o(rdg), .rdg_stb_o(stb), .dig_irq_o(dirq), .irq_o(irq));
  dioia_host u_host (.clk_i(clk_i), .addr_o(adr), .rd_o(rd), .wr_o(wr), .wdata_o(wd), .rdata_i(rdat),
    .wait_i(wt));

  // 25 ns clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Flags a channel edge would set for a given sense value
  function automatic logic [7:0] exp_flags(input logic [7:0] s, input logic [7:0] o, input logic [7:0] n);
    return (s & ~o & n) | (~s & o & ~n);
  endfunction

  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_host.access(1'b1, a, d, x);
  endtask
  task automatic rreg(input logic [5:0] a);
    u_host.access(1'b0, a, 32'h0, q);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic settle();
    @(negedge clk_i);
  endtask
  task automatic set_din(input logic [15:0] x);
    @(posedge clk_i);
    din <= x;
    settle();
    settle();
  endtask
  // Bounded wait for a reading pulse
  task automatic wait_stb(input int lim, output bit f);
    int n;
    f = 0;
    for (n = 0; n < lim && !f; n++) begin
      settle();
      f = (stb === 1'b1);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog sized well above the three reading periods the tests need
  initial begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    $display("unexpected timeout expected done seen hang");
    conclude();
  end

  initial begin
    rst_i = 1'b1;
    din = 16'h0000;
    void'($urandom(27448));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values
    rreg(OFS_MASK); chk("mask", {24'h0, MASK_RST}, q);
    rreg(OFS_SENSE); chk("sense", {24'h0, SENSE_RST}, q);
    rreg(OFS_CTRL); chk("ctrl", 32'h0, q);
    chk("dout", {16'h0, OUT_RST}, {16'h0, dout});
    mdl = OUT_RST;
    $display("test reset done");
    // Output channel commands, full-scale corner first
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 16'h0000 : 16'($urandom);
      wreg(OFS_WORD, {16'h0, v}); mdl = v; settle();
      chk("word", {16'h0, mdl}, {16'h0, dout});
      v = (i == 0) ? 16'hFFFF : 16'($urandom);
      wreg(OFS_CLOSE, {16'h0, v}); mdl = mdl | v; settle();
      chk("close", {16'h0, mdl}, {16'h0, dout});
      v = (i == 0) ? 16'hFFFF : 16'($urandom);
      wreg(OFS_OPEN, {16'h0, v}); mdl = mdl & ~v; settle();
      chk("open", {16'h0, mdl}, {16'h0, dout});
    end
    wreg(OFS_WORD, 32'h0000A5C3); mdl = 16'hA5C3;
    wreg(OFS_CTRL, 32'h1); rreg(OFS_LOAD);
    chk("load out", {16'h0, mdl}, q);
    wreg(OFS_CTRL, 32'h3); rreg(OFS_LOAD);
    chk("load narrow", {24'h0, mdl[7:0]}, q);
    wreg(OFS_CTRL, 32'h0); set_din(16'($urandom)); rreg(OFS_LOAD);
    chk("load in", {16'h0, din}, q);
    $display("test outputs done");
    // Continuous readings follow the inputs
    wreg(OFS_CONT, 32'h1); wait_stb(20, got);
    chk("first rdg", 32'h1, {31'h0, got});
    chk("rdg", {16'h0, din}, {16'h0, rdg});
    set_din(16'($urandom)); wait_stb(SAMPLE_CYC + 100, got);
    chk("next rdg", {16'h0, din}, {16'h0, rdg});
    wreg(OFS_CONT, 32'h0);
    // Single output mode: one reading for one start
    wreg(OFS_CTRL, 32'h4); wreg(OFS_CONT, 32'h1); wait_stb(20, got);
    chk("single rdg", 32'h1, {31'h0, got});
    settle(); wait_stb(2 * SAMPLE_CYC + 100, got);
    chk("extra rdg", 32'h0, {31'h0, got});
    wreg(OFS_CTRL, 32'h0);
    $display("test readings done");
    // Edge-sensed flags, mask and clear on read
    set_din(16'h0000);
    wreg(OFS_MASK, 32'h04); wreg(OFS_SENSE, 32'h0F); rreg(OFS_FLAG); settle();
    chk("irq idle", 32'h0, {31'h0, dirq});
    set_din(16'h0055);
    chk("irq rise", 32'h1, {31'h0, dirq});
    rreg(OFS_FLAG);
    chk("flags rise", {24'h0, exp_flags(8'h0F, 8'h00, 8'h55)}, q);
    settle(); chk("irq cleared", 32'h0, {31'h0, dirq});
    set_din(16'h0000);
    chk("irq masked", 32'h0, {31'h0, dirq});
    wreg(OFS_MASK, 32'h10); repeat (5) settle();
    chk("irq held", 32'h1, {31'h0, dirq});
    rreg(OFS_FLAG);
    chk("flags fall", {24'h0, exp_flags(8'h0F, 8'h55, 8'h00)}, q);
    rreg(OFS_FLAG); chk("flags empty", 32'h0, q);
    $display("test flags done");
    // Bus interrupt: unmapped access event, masked, enabled, cleared
    wreg(OFS_ICLR, 32'h7); wreg(OFS_IEN, 32'h3);
    rreg(6'h30); chk("unmapped", 32'h0, q);
    settle(); chk("bus irq masked", 32'h0, {31'h0, irq});
    wreg(OFS_IEN, 32'h4); settle(); chk("bus irq", 32'h1, {31'h0, irq});
    wreg(OFS_ICLR, 32'h4); settle(); chk("bus irq clr", 32'h0, {31'h0, irq});
    $display("test bus irq done");
    // Reinit returns outputs, flags, mask and sense to reset values
    set_din(16'h0001);
    wreg(OFS_WORD, 32'h00001234); wreg(OFS_CTRL, 32'h8); settle();
    chk("reinit dout", {16'h0, OUT_RST}, {16'h0, dout});
    rreg(OFS_FLAG); chk("reinit flags", 32'h0, q);
    rreg(OFS_MASK); chk("reinit mask", {24'h0, MASK_RST}, q);
    rreg(OFS_SENSE); chk("reinit sense", {24'h0, SENSE_RST}, q);
    $display("test reinit done");
    conclude();
  end
endmodule // tb_digital_io_interrupt_assembly
`default_nettype wire
